// *** aosf_pkg.sv ***
// constants and types shared by the adc output serial formatter
package aosf_pkg;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_DRIVE   = 8'h04;
	localparam logic [7:0]  OFS_CUST_LO = 8'h08;
	localparam logic [7:0]  OFS_CUST_HI = 8'h0c;
	localparam logic [7:0]  OFS_STATUS  = 8'h10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// field positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_LSB_FIRST  = 0;
	localparam int          CTRL_OFFSET_BIN = 1;
	localparam int          CTRL_PAT_LSB    = 2;
	localparam int          CTRL_TWO_LANE   = 5;
	localparam int          CTRL_SER14      = 6;
	localparam int          CTRL_SDR        = 7;
	localparam int          CTRL_ORDER_LSB  = 8;
	localparam int          CTRL_LONG_PD    = 10;
	localparam int          DRV_CURR_LSB    = 0;
	localparam int          DRV_DOUBLE      = 2;
	localparam int          DRV_TCLK_LSB    = 3;
	localparam int          DRV_TDATA_LSB   = 8;
	localparam logic [31:0] CTRL_MASK       = 32'h0000_07ff;
	localparam logic [31:0] DRIVE_MASK      = 32'h0000_1fff;
	localparam logic [31:0] CUST_LO_MASK    = 32'h0000_00ff;
	localparam logic [31:0] CUST_HI_MASK    = 32'h0000_000f;
	localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
	localparam logic [31:0] DRIVE_RST       = 32'h0000_0000;
	localparam logic [31:0] CUST_RST        = 32'h0000_0000;

	// ----------------------------------------------------------------
	// data codes and timing
	// ----------------------------------------------------------------
	localparam int          CONV_LATENCY = 12;
	localparam logic [11:0] FS_POS_OB    = 12'hfff;
	localparam logic [11:0] FS_POS_TC    = 12'h7ff;
	localparam logic [11:0] FS_NEG_OB    = 12'h000;
	localparam logic [11:0] FS_NEG_TC    = 12'h800;
	localparam logic [11:0] TC_FLIP      = 12'h800;
	localparam logic [11:0] WORD_ZEROS   = 12'h000;
	localparam logic [11:0] WORD_ONES    = 12'hfff;
	localparam logic [11:0] TOGGLE_A     = 12'haaa;
	localparam logic [11:0] TOGGLE_B     = 12'h555;
	localparam logic [11:0] DESKEW_WORD  = 12'haaa;
	localparam logic [13:0] SYNC_1W12    = 14'h0fc0;
	localparam logic [13:0] SYNC_1W14    = 14'h3f80;
	localparam logic [13:0] SYNC_2W12    = 14'h0038;
	localparam logic [13:0] SYNC_2W14    = 14'h0078;
	localparam logic [3:0]  LEN_12       = 4'hc;
	localparam logic [3:0]  LEN_14       = 4'he;

	typedef enum logic [2:0] {
		PAT_OFF    = 3'h0,
		PAT_ZEROS  = 3'h1,
		PAT_ONES   = 3'h2,
		PAT_TOGGLE = 3'h3,
		PAT_CUSTOM = 3'h4,
		PAT_SYNC   = 3'h5,
		PAT_DESKEW = 3'h6,
		PAT_RSVD   = 3'h7
	} aosf_pat_t;

	typedef enum logic [1:0] {
		ORD_BYTE = 2'h0,
		ORD_BIT  = 2'h1,
		ORD_WORD = 2'h2,
		ORD_RSVD = 2'h3
	} aosf_order_t;

	typedef enum logic [1:0] {
		CUR_3P5 = 2'h0,
		CUR_2P5 = 2'h1,
		CUR_3P0 = 2'h2,
		CUR_4P5 = 2'h3
	} aosf_curr_t;

endpackage

// *** aosf_lane_ser.sv ***
// two-lane shift register pair of one channel
module aosf_lane_ser
	import aosf_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        load0,
	input  wire logic        load1,
	input  wire logic        step,
	input  wire logic [13:0] word0,
	input  wire logic [13:0] word1,
	output logic             lane0,
	output logic             lane1
);

	logic [13:0] shift0;
	logic [13:0] shift1;

	// ----------------------------------------------------------------
	// lane 0
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift0 <= 14'h0000;
			lane0  <= 1'b0;
		end else if (load0) begin
			lane0  <= word0[13];
			shift0 <= {word0[12:0], 1'b0};
		end else if (step) begin
			lane0  <= shift0[13];
			shift0 <= {shift0[12:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// lane 1
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift1 <= 14'h0000;
			lane1  <= 1'b0;
		end else if (load1) begin
			lane1  <= word1[13];
			shift1 <= {word1[12:0], 1'b0};
		end else if (step) begin
			lane1  <= shift1[13];
			shift1 <= {shift1[12:0], 1'b0};
		end
	end

endmodule

// *** aosf_serial_formatter.sv ***
// adc output formatter: coding, test patterns, latency and lane serializer
// How it works
// - msb first after reset, lsb first selectable
// - lsb first reverses bits within each lane
// - two's complement default, offset binary selectable
// - positive overrange gives full-scale positive code
// - negative overrange gives full-scale negative code
// - drive current select plus current doubling
// - separate clock and data termination selects
// - toggle pattern alternates every sample
// - deskew pattern is fixed alternating bits
// - custom twelve-bit word, mapped like data
// - sync pattern depends on lanes, serialization
// - patterns appear on both channels together
// - serializer latency per interface option
// - total latency twelve plus serializer latency
// - byte-wise: lane0 low half (six, or seven in fourteen-bit mode), lane1 high
// - bit-wise: lane0 even bits, lane1 odd
// - word-wise alternates lanes, half-rate frame clock
// - fourteen-bit mode pads two msb zeros
module aosf_serial_formatter
	import aosf_pkg::*;
#(
	parameter int BIT_CYCLES = 2,
	parameter int CONV_LAT   = CONV_LATENCY
)(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              sample_clk,
	input  wire logic [11:0]       adcA,
	input  wire logic              adcAOverPos,
	input  wire logic              adcAOverNeg,
	input  wire logic [11:0]       adcB,
	input  wire logic              adcBOverPos,
	input  wire logic              adcBOverNeg,
	output logic                   chanALane0,
	output logic                   chanALane1,
	output logic                   chanBLane0,
	output logic                   chanBLane1,
	output logic                   serialBitClock,
	output logic                   frameClock,
	output logic [1:0]             driveCurrentSelect,
	output logic                   currentDoubleEnable,
	output logic [4:0]             termClkSelect,
	output logic [4:0]             termDataSelect,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	localparam int          PIPE_D = CONV_LAT + 2;
	localparam int          IDX_W  = $clog2(PIPE_D);
	localparam logic [7:0]  BIT_LD = 8'(BIT_CYCLES - 1);
	localparam logic [7:0]  BIT_MID = 8'(BIT_CYCLES / 2);

	if (BIT_CYCLES < 2 || BIT_CYCLES > 255 || CONV_LAT < 1) begin : g_bad_param
		$error("aosf_serial_formatter: unsupported BIT_CYCLES or CONV_LAT");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [11:0] fmtSample(input logic [11:0] raw, input logic pos,
			input logic neg, input logic ob);
		if (pos)
			return ob ? FS_POS_OB : FS_POS_TC;
		if (neg)
			return ob ? FS_NEG_OB : FS_NEG_TC;
		return ob ? raw : (raw ^ TC_FLIP);
	endfunction

	// returns {lane1, lane0}, each right aligned
	function automatic logic [27:0] mapLanes(input logic [13:0] d, input logic [3:0] half,
			input logic two, input aosf_order_t ord);
		logic [13:0] l0;
		logic [13:0] l1;
		int          j;
		l0 = d;
		l1 = d;
		if (two && ord == ORD_BYTE) begin
			l0 = d & ~(14'h3fff << half);
			l1 = d >> half;
		end else if (two && ord == ORD_BIT) begin
			l0 = 14'h0000;
			l1 = 14'h0000;
			for (j = 0; j < 7; j++) begin
				l0[j] = d[2*j];
				l1[j] = d[2*j+1];
			end
		end
		return {l1, l0};
	endfunction

	// left aligns len bits in send order
	function automatic logic [13:0] buildLane(input logic [13:0] w, input logic [3:0] len,
			input logic lsb);
		logic [13:0] r;
		int          i;
		r = 14'h0000;
		for (i = 0; i < 14; i++) begin
			if (i < int'(len))
				r[13-i] = lsb ? w[i] : w[int'(len)-1-i];
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		int          b;
		r = old;
		for (b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b+:8] = nw[8*b+:8];
		end
		return r & mask;
	endfunction

	// ----------------------------------------------------------------
	// registers and decoded configuration
	// ----------------------------------------------------------------
	logic [31:0]       ctrlReg;
	logic [31:0]       driveReg;
	logic [31:0]       custLo;
	logic [31:0]       custHi;
	logic              lsbFirst;
	logic              offsetBin;
	aosf_pat_t         pat;
	logic              twoLane;
	logic              ser14;
	logic              sdrClk;
	aosf_order_t       order;
	logic              longPd;
	logic              wordWise;
	logic [3:0]        wordLen;
	logic [3:0]        halfLen;
	logic [3:0]        slotsPerSample;
	logic [1:0]        serLat;
	logic [IDX_W-1:0]  latIdx;

	assign lsbFirst  = ctrlReg[CTRL_LSB_FIRST];
	assign offsetBin = ctrlReg[CTRL_OFFSET_BIN];
	assign pat       = aosf_pat_t'(ctrlReg[CTRL_PAT_LSB+:3]);
	assign twoLane   = ctrlReg[CTRL_TWO_LANE];
	assign ser14     = ctrlReg[CTRL_SER14];
	assign sdrClk    = ctrlReg[CTRL_SDR] & twoLane;
	assign order     = aosf_order_t'(ctrlReg[CTRL_ORDER_LSB+:2]);
	assign longPd    = ctrlReg[CTRL_LONG_PD];
	assign wordWise  = twoLane && order == ORD_WORD;
	assign wordLen   = ser14 ? LEN_14 : LEN_12;
	assign halfLen   = wordLen >> 1;
	assign slotsPerSample = twoLane ? halfLen : wordLen;
	assign serLat    = (twoLane && !sdrClk) ? ((ser14 && longPd) ? 2'h2 : 2'h1) : 2'h0;
	assign latIdx    = IDX_W'(CONV_LAT + int'(serLat) - 1);

	assign driveCurrentSelect  = driveReg[DRV_CURR_LSB+:2];
	assign currentDoubleEnable = driveReg[DRV_DOUBLE];
	assign termClkSelect       = driveReg[DRV_TCLK_LSB+:5];
	assign termDataSelect      = driveReg[DRV_TDATA_LSB+:5];

	// ----------------------------------------------------------------
	// sample clock synchroniser and edge detect
	// ----------------------------------------------------------------
	logic sclkMeta;
	logic sclkSync;
	logic sclkPrev;
	logic sampleEdge;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkMeta <= 1'b0;
			sclkSync <= 1'b0;
			sclkPrev <= 1'b0;
		end else begin
			sclkMeta <= sample_clk;
			sclkSync <= sclkMeta;
			sclkPrev <= sclkSync;
		end
	end
	assign sampleEdge = sclkSync & ~sclkPrev;

	// ----------------------------------------------------------------
	// conversion pipeline
	// ----------------------------------------------------------------
	logic [11:0] pipeA [PIPE_D];
	logic [11:0] pipeB [PIPE_D];
	logic        phase;
	logic [15:0] sampleCount;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < PIPE_D; k++) begin
				pipeA[k] <= 12'h000;
				pipeB[k] <= 12'h000;
			end
		end else if (sampleEdge) begin
			pipeA[0] <= fmtSample(adcA, adcAOverPos, adcAOverNeg, offsetBin);
			pipeB[0] <= fmtSample(adcB, adcBOverPos, adcBOverNeg, offsetBin);
			for (int k = 1; k < PIPE_D; k++) begin
				pipeA[k] <= pipeA[k-1];
				pipeB[k] <= pipeB[k-1];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase       <= 1'b0;
			sampleCount <= 16'h0000;
		end else if (sampleEdge) begin
			phase       <= ~phase;
			sampleCount <= sampleCount + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// pattern substitution and lane words
	// ----------------------------------------------------------------
	logic [11:0] patWord;
	logic [11:0] wordA;
	logic [11:0] wordB;
	logic [27:0] lanesA;
	logic [27:0] lanesB;
	logic [13:0] syncWord;
	logic [3:0]  laneLen;
	logic        isSync;
	logic [13:0] ldA0;
	logic [13:0] ldA1;
	logic [13:0] ldB0;
	logic [13:0] ldB1;

	always_comb begin
		unique case (pat)
			PAT_ZEROS:  patWord = WORD_ZEROS;
			PAT_ONES:   patWord = WORD_ONES;
			PAT_TOGGLE: patWord = phase ? TOGGLE_B : TOGGLE_A;
			PAT_CUSTOM: patWord = {custHi[3:0], custLo[7:0]};
			PAT_DESKEW: patWord = DESKEW_WORD;
			default:    patWord = WORD_ZEROS;
		endcase
		isSync = pat == PAT_SYNC;
		// one pattern word feeds both channels
		wordA  = (pat == PAT_OFF || pat == PAT_RSVD) ? pipeA[latIdx] : patWord;
		wordB  = (pat == PAT_OFF || pat == PAT_RSVD) ? pipeB[latIdx] : patWord;
		lanesA = mapLanes({2'b00, wordA}, halfLen, twoLane, order);
		lanesB = mapLanes({2'b00, wordB}, halfLen, twoLane, order);
		laneLen = (twoLane && !wordWise) ? halfLen : wordLen;
		if (twoLane && !wordWise)
			syncWord = ser14 ? SYNC_2W14 : SYNC_2W12;
		else
			syncWord = ser14 ? SYNC_1W14 : SYNC_1W12;
		if (isSync) begin
			ldA0 = buildLane(syncWord, laneLen, 1'b0);
			ldA1 = ldA0;
			ldB0 = ldA0;
			ldB1 = ldA0;
		end else begin
			ldA0 = buildLane(lanesA[13:0], laneLen, lsbFirst);
			ldA1 = buildLane(lanesA[27:14], laneLen, lsbFirst);
			ldB0 = buildLane(lanesB[13:0], laneLen, lsbFirst);
			ldB1 = buildLane(lanesB[27:14], laneLen, lsbFirst);
		end
	end

	// ----------------------------------------------------------------
	// bit slot timing, bit clock and frame clock
	// ----------------------------------------------------------------
	logic [7:0] bitTimer;
	logic [3:0] slotsLeft;
	logic       slotActive;
	logic       tick;
	logic       load0;
	logic       load1;

	assign tick  = slotActive & (bitTimer == 8'h00) & (slotsLeft != 4'h0) & ~sampleEdge;
	// word-wise: even samples go to lane 0, odd ones to lane 1
	assign load0 = sampleEdge & (~wordWise | ~phase);
	assign load1 = sampleEdge & twoLane & (~wordWise | phase);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitTimer   <= 8'h00;
			slotsLeft  <= 4'h0;
			slotActive <= 1'b0;
		end else if (sampleEdge) begin
			bitTimer   <= BIT_LD;
			slotsLeft  <= slotsPerSample - 4'h1;
			slotActive <= 1'b1;
		end else if (slotActive) begin
			if (bitTimer != 8'h00) begin
				bitTimer <= bitTimer - 8'h01;
			end else if (slotsLeft != 4'h0) begin
				bitTimer  <= BIT_LD;
				slotsLeft <= slotsLeft - 4'h1;
			end else begin
				slotActive <= 1'b0;
			end
		end
	end

	// clock outputs run the same whatever the data source
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			serialBitClock <= 1'b0;
		end else if (slotActive && !sampleEdge) begin
			if (bitTimer == BIT_MID)
				serialBitClock <= sdrClk ? 1'b1 : ~serialBitClock;
			else if (sdrClk && bitTimer == 8'h00)
				serialBitClock <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frameClock <= 1'b0;
		end else if (sampleEdge) begin
			frameClock <= wordWise ? ~phase : 1'b1;
		end else if (tick && !wordWise) begin
			if (slotsLeft == slotsPerSample - (slotsPerSample >> 1))
				frameClock <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// channel serializers
	// ----------------------------------------------------------------
	aosf_lane_ser u_chan_a (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.load0   (load0),
		.load1   (load1),
		.step    (sampleEdge | tick),
		.word0   (ldA0),
		.word1   (ldA1),
		.lane0   (chanALane0),
		.lane1   (chanALane1)
	);

	aosf_lane_ser u_chan_b (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.load0   (load0),
		.load1   (load1),
		.step    (sampleEdge | tick),
		.word0   (ldB0),
		.word1   (ldB1),
		.lane0   (chanBLane0),
		.lane1   (chanBLane1)
	);

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic              awHeld;
	logic              wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0]       wData;
	logic [3:0]        wStrb;
	logic              doWrite;
	logic              next_awHeld;
	logic              next_wHeld;
	logic              next_bvalid;
	logic [7:0]        wAddr;

	assign doWrite     = awHeld & wHeld & ~s_axi_bvalid;
	assign next_awHeld = (awHeld & ~doWrite) | (s_axi_awvalid & s_axi_awready);
	assign next_wHeld  = (wHeld & ~doWrite) | (s_axi_wvalid & s_axi_wready);
	assign next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);
	assign wAddr       = {awAddr[ADDR_W-1:2], 2'b00};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			awAddr        <= '0;
			wData         <= 32'h0000_0000;
			wStrb         <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			awHeld        <= next_awHeld;
			wHeld         <= next_wHeld;
			s_axi_awready <= ~next_awHeld & ~next_bvalid;
			s_axi_wready  <= ~next_wHeld & ~next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			if (s_axi_awvalid && s_axi_awready)
				awAddr <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				unique case (wAddr)
					OFS_CTRL, OFS_DRIVE, OFS_CUST_LO, OFS_CUST_HI, OFS_STATUS:
						s_axi_bresp <= RESP_OKAY;
					default:
						s_axi_bresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlReg  <= CTRL_RST;
			driveReg <= DRIVE_RST;
			custLo   <= CUST_RST;
			custHi   <= CUST_RST;
		end else if (doWrite) begin
			if (wAddr == OFS_CTRL)
				ctrlReg <= merge(ctrlReg, wData, wStrb, CTRL_MASK);
			if (wAddr == OFS_DRIVE)
				driveReg <= merge(driveReg, wData, wStrb, DRIVE_MASK);
			if (wAddr == OFS_CUST_LO)
				custLo <= merge(custLo, wData, wStrb, CUST_LO_MASK);
			if (wAddr == OFS_CUST_HI)
				custHi <= merge(custHi, wData, wStrb, CUST_HI_MASK);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	logic       next_rvalid;
	logic [7:0] rAddr;

	assign next_rvalid = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);
	assign rAddr       = {s_axi_araddr[ADDR_W-1:2], 2'b00};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rresp <= RESP_OKAY;
				unique case (rAddr)
					OFS_CTRL:    s_axi_rdata <= ctrlReg;
					OFS_DRIVE:   s_axi_rdata <= driveReg;
					OFS_CUST_LO: s_axi_rdata <= custLo;
					OFS_CUST_HI: s_axi_rdata <= custHi;
					OFS_STATUS:  s_axi_rdata <= {8'h00, phase, serLat,
						5'(CONV_LAT + int'(serLat)), sampleCount};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

endmodule

// *** aosf_chk_asserts.sv ***
// bus and drive assertions for the formatter
module aosf_chk
	import aosf_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [1:0]        driveCurrentSelect,
	input wire logic [4:0]        termDataSelect
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7:2] > OFS_STATUS[7:2]
		|-> ##[1:2] s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	a_drive_cause: assert property ($changed({termDataSelect, driveCurrentSelect})
		|-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("drive setting changed without write");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property ($changed(driveCurrentSelect));
endmodule

bind aosf_serial_formatter aosf_chk i_aosf_chk (.*);

// *** aosf_rx_model.sv ***
// receiver model: deserialises one lane on bit clock edges
module aosf_rx_model (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        bitClk,
	input  wire logic        frame,
	input  wire logic        lane,
	input  wire logic [3:0]  nBits,
	output logic      [13:0] word
);
	logic        lastClk;
	logic        lastFrame;
	logic [3:0]  count;
	logic [13:0] shift;

	// frame start restarts the count, each bit clock edge takes a bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastClk <= 1'h0;
			lastFrame <= 1'h0;
			count <= 4'hf;
			shift <= '0;
			word <= '0;
		end else begin
			lastClk <= bitClk;
			lastFrame <= frame;
			if (frame && !lastFrame) begin
				count <= 4'h0;
				shift <= '0;
			end else if (bitClk != lastClk && count != 4'hf) begin
				shift <= {shift[12:0], lane};
				count <= count + 4'h1;
				if (count == nBits - 4'h1) begin
					word <= {shift[12:0], lane};
				end
			end
		end
	end
endmodule

// *** tb_top.sv ***
// self-checking bench for the formatter
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import aosf_pkg::*;

	logic ref_clk = '0, rst_n = '0, sample_clk = '0;
	logic [11:0] adcA = '0, adcB = '0;
	logic adcAOverPos = '0, adcAOverNeg = '0, adcBOverPos = '0, adcBOverNeg = '0;
	logic chanALane0, chanALane1, chanBLane0, chanBLane1, serialBitClock, frameClock;
	logic [1:0] driveCurrentSelect, s_axi_bresp, s_axi_rresp;
	logic currentDoubleEnable, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [4:0] termClkSelect, termDataSelect;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, rxBits = 4'hc;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic [13:0] rxA, rxB, rxC, rxD, w;
	logic [1:0] r;
	int fails = 0, checked = 0;

	aosf_serial_formatter i_aosf_serial_formatter (.*);
	aosf_rx_model i_aosf_rx_model_a (.ref_clk, .rst_n, .bitClk(serialBitClock), .frame(frameClock),
		.lane(chanALane0), .nBits(rxBits), .word(rxA));
	aosf_rx_model i_aosf_rx_model_b (.ref_clk, .rst_n, .bitClk(serialBitClock), .frame(frameClock),
		.lane(chanBLane0), .nBits(rxBits), .word(rxB));
	aosf_rx_model i_aosf_rx_model_c (.ref_clk, .rst_n, .bitClk(serialBitClock), .frame(frameClock),
		.lane(chanALane1), .nBits(rxBits), .word(rxC));
	aosf_rx_model i_aosf_rx_model_d (.ref_clk, .rst_n, .bitClk(serialBitClock), .frame(frameClock),
		.lane(chanBLane1), .nBits(rxBits), .word(rxD));

	initial forever #2 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #80 sample_clk = ~sample_clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// waits out conversion latency, then compares both channels
	task automatic run(input logic [13:0] e);
		repeat (800) @(posedge ref_clk);
		chk(32'(rxA), 32'(e));
		chk(32'(rxB), 32'(e));
	endtask

	task automatic feed(input logic [11:0] v, input logic p, input logic n);
		adcA <= v;
		adcB <= v;
		{adcAOverPos, adcBOverPos} <= {p, p};
		{adcAOverNeg, adcBOverNeg} <= {n, n};
	endtask

	task automatic end_of_test();
		if (fails == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	logic [11:0] fs[4] = '{FS_POS_TC, FS_NEG_TC, FS_POS_OB, FS_NEG_OB};
	logic [11:0] pc[5] = '{12'h004, 12'h008, 12'h010, 12'h014, 12'h018};
	logic [11:0] pe[5] = '{12'h000, 12'hfff, 12'h6c9, 12'hfc0, 12'haaa};
	logic [11:0] lc[5] = '{12'h000, 12'h020, 12'h060, 12'h460, 12'h0a0};
	logic [6:0] le[5] = '{7'h0c, 7'h2d, 7'h2d, 7'h4e, 7'h0c};

	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		rd(OFS_CTRL);
		chk(d, CTRL_RST);
		rd(8'h20);
		chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DRIVE, 32'h1b54 | i);
			chk({termDataSelect, termClkSelect, currentDoubleEnable, driveCurrentSelect}, 32'h1b54 | i);
		end
		feed(12'h3a5, 1'h0, 1'h0);
		run(14'h0ba5);
		wr(OFS_CTRL, 32'h1);
		run(14'h0a5d);
		wr(OFS_CTRL, 32'h2);
		run(14'h03a5);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL, i[1] ? 32'h2 : 32'h0);
			feed(12'h3a5, !i[0], i[0]);
			run({2'h0, fs[i]});
		end
		wr(OFS_CUST_LO, 32'hc9);
		wr(OFS_CUST_HI, 32'h6);
		for (int k = 0; k < 5; k++) begin
			wr(OFS_CTRL, 32'(pc[k]));
			run({2'h0, pe[k]});
		end
		wr(OFS_CTRL, 32'h0c);
		repeat (80) @(posedge ref_clk);
		w = rxA;
		repeat (40) @(posedge ref_clk);
		chk(32'(w ^ rxA), 32'hfff);
		rxBits <= 4'he;
		wr(OFS_CTRL, 32'h54);
		run(14'h3f80);
		feed(12'h3a5, 1'h0, 1'h0);
		wr(OFS_CTRL, 32'h42);
		run(14'h03a5);
		rxBits <= 4'h6;
		wr(OFS_CTRL, 32'h22);
		run(14'h0025);
		chk(32'(rxC), 32'h0e);
		chk(32'(rxD), 32'h0e);
		wr(OFS_CTRL, 32'h123);
		run(14'h0032);
		chk(32'(rxC), 32'h0e);
		chk(32'(rxD), 32'h0e);
		for (int k = 0; k < 5; k++) begin
			wr(OFS_CTRL, 32'(lc[k]));
			rd(OFS_STATUS);
			chk(32'(d[22:16]), 32'(le[k]));
		end
		end_of_test();
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		end_of_test();
	end
endmodule
